// ==== c8rs_irq_src.sv ====
// Interrupt source model that drives each request line from its fire input one clock later.
`default_nettype none
module c8rs_irq_src (
   input  wire logic clk,
   input  wire logic fire_tmr,
   input  wire logic fire_ext,
   output logic      irq_timer,
   output logic      irq_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk)
   begin
      irq_timer <= fire_tmr;
      irq_ext   <= fire_ext;
   end
endmodule // c8rs_irq_src
`default_nettype wire

// ==== c8rs_mul.sv ====
// Unsigned 8 by 8 multiplier built from add and shift steps.
`default_nettype none
module c8rs_mul #(
   parameter int unsigned CYCLES = c8rs_pkg::MUL_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [7:0]  mcand,
   input  wire logic [7:0]  mplier,
   output logic             done,
   output logic      [15:0] product
);
   if (CYCLES < 9 || CYCLES > 15)
   begin : g_bad_cycles
      $error("c8rs_mul: CYCLES must be 9..15");
   end

   typedef struct packed {
      logic [3:0]  cnt;
      logic [7:0]  mc;
      logic [16:0] p;
   } c8rs_mul_st_t;

   c8rs_mul_st_t s;
   c8rs_mul_st_t n;
   logic [8:0]   part;

   // One add and shift per step over the first eight cycles.
   always_comb
   begin
      n = s;
      part = {1'b0, s.p[15:8]} + (s.p[0] ? {1'b0, s.mc} : 9'h000);
      if (start)
      begin
         n.cnt = 4'h1;
         n.mc = mcand;
         n.p = {9'h000, mplier};
      end
      else if (s.cnt != 4'h0)
      begin
         if (s.cnt <= 4'h8)
         begin
            n.p = {1'b0, part, s.p[7:1]};
         end
         n.cnt = (s.cnt == 4'(CYCLES)) ? 4'h0 : 4'(s.cnt + 4'h1);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign done = (s.cnt == 4'(CYCLES));
   assign product = s.p[15:0];

   a_mul_cycles: assert property (@(posedge clk) disable iff (!resetn)
      start |-> !done [*8] ##1 !done [*3] ##1 done)
      else $error("multiply did not finish in eleven cycles");
   a_mul_value: assert property (@(posedge clk) disable iff (!resetn)
      start |-> ##11 (product == $past(mcand, 11) * $past(mplier, 11)))
      else $error("multiply gave a wrong product");
endmodule // c8rs_mul
`default_nettype wire

// ==== c8rs_pkg.sv ====
// Shared constants and types of the CPU register set.
`default_nettype none
package c8rs_pkg;
   // Flag positions inside the condition flags byte.
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_Z = 1;
   localparam int unsigned FLG_N = 2;
   localparam int unsigned FLG_I = 3;
   localparam int unsigned FLG_H = 4;
   localparam logic [2:0]  FLG_UPPER_ONES = 3'h7;
   localparam logic [4:0]  FLG_RESET      = 5'h08;
   // Stack page and top of stack.
   localparam logic [6:0]  STK_PAGE_BITS  = 7'h03;
   localparam logic [5:0]  STK_TOP        = 6'h3F;
   localparam logic [2:0]  PC_UPPER_ZERO  = 3'h0;
   localparam logic [7:0]  IX0_HIGH       = 8'h00;
   localparam logic [2:0]  PUSH_CALL      = 3'h2;
   localparam logic [2:0]  PUSH_IRQ       = 3'h5;
   localparam logic [2:0]  PULL_RET_TOP   = 3'h1;
   localparam logic [2:0]  PULL_IRQ_TOP   = 3'h4;
   localparam int unsigned MUL_CYCLES     = 11;
   // Control port byte offsets.
   localparam logic [7:0]  REG_CMD        = 8'h00;
   localparam logic [7:0]  REG_OPND       = 8'h04;
   localparam logic [7:0]  REG_ACC        = 8'h08;
   localparam logic [7:0]  REG_IDX        = 8'h0C;
   localparam logic [7:0]  REG_STACK      = 8'h10;
   localparam logic [7:0]  REG_PC         = 8'h14;
   localparam logic [7:0]  REG_FLAGS      = 8'h18;
   localparam logic [7:0]  REG_EA         = 8'h1C;
   localparam logic [7:0]  REG_STATUS     = 8'h20;

   typedef enum logic [4:0] {
      op_nop, op_load_acc, op_load_idx, op_add, op_add_carry, op_sub,
      op_and, op_or, op_xor, op_shift_left, op_shift_right, op_rot_left,
      op_rot_right, op_acc_to_idx, op_idx_to_acc, op_clear_carry,
      op_set_carry, op_clear_mask, op_set_mask, reload_stack_top_op,
      op_fetch, op_jump, op_subr_call, op_subr_return,
      return_from_interrupt_op, product_op, op_index_none, op_index_off8,
      op_index_off16, op_bit_test
   } c8rs_op_t;

   typedef enum logic [1:0] {st_idle, st_push, st_pull, st_mul} c8rs_state_t;
endpackage
`default_nettype wire

// ==== c8rs_register_set.sv ====
// Programmer-visible register set of an 8-bit CPU with a control port.
// Notes on behaviour
// - Accumulator is 8-bit operand and result register.
// - No-offset index address is zero high byte.
// - Eight-bit offset address is index plus offset.
// - Sixteen-bit offset address is index plus offset.
// - Reset and reload op set stack top.
// - Push decrements, pull increments the stack pointer.
// - Stack addresses fixed upper bits, 64-byte page.
// - Stack pointer wraps silently within its page.
// - Call pushes two bytes, interrupt pushes five.
// - Program counter 13 bits, upper three zero.
// - Counter advances per fetch; jumps load target.
// - Five flag bits, upper three read one.
// - Half-carry is carry out of bit three.
// - Set mask blocks timer and external interrupts.
// - Mask set after stacking, in the same cycle as vector load.
// - Masked requests stay pending until mask clears.
// - Interrupt return restores all stacked registers.
// - Reset sets mask; only instructions clear it.
// - CPU registers are outside the memory map.
// - Unsigned eight by eight multiply supported.
// - Negative flag copies result bit seven.
// - Zero flag set on zero result.
// - Carry from bit seven, shifts, bit tests.
// - Multiply takes eleven cycles, eight of them add/shift.
//
// The address map and the Wishbone register port are this design's own decisions.
`default_nettype none
module c8rs_register_set #(
   parameter logic [12:0] VEC_TIMER = 13'h1000,
   parameter logic [12:0] VEC_EXT   = 13'h1002
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        irq_timer,
   input  wire logic        irq_ext,
   output logic      [15:0] stack_addr,
   output logic      [15:0] prog_addr
);
   typedef struct packed {
      logic [7:0]          acc;
      logic [7:0]          idx;
      logic [5:0]          stack_ptr;
      logic [12:0]         program_counter;
      logic [4:0]          condition_flags;
      logic [15:0]         ea;
      logic [15:0]         opnd;
      c8rs_pkg::c8rs_state_t state;
      logic [2:0]          cnt;
      logic [2:0]          nbytes;
      logic                irq_entry;
      logic                vec_ext;
      logic                phase;
      logic [1:0]          pend;
      logic                ack;
      logic [31:0]         rdat;
   } c8rs_core_st_t;

   c8rs_core_st_t       s;
   c8rs_core_st_t       n;
   c8rs_pkg::c8rs_op_t  cmd_op;
   logic                wr;
   logic                cmd_go;
   logic                irq_take;
   logic [1:0]          take_mask;
   logic [31:0]         rd_value;
   logic                ram_we;
   logic [5:0]          ram_addr;
   logic [7:0]          ram_wdata;
   logic [7:0]          ram_rdata;
   logic                mul_start;
   logic                mul_done;
   logic [15:0]         mul_product;
   logic [8:0]          sum9;
   logic [4:0]          nib;
   logic                cin;
   logic [7:0]          nz_val;
   logic                nz_upd;
   logic [7:0]          opb;

   // Byte order on the stack, lowest index pushed first.
   function automatic logic [7:0] push_byte(input logic [2:0] i, input c8rs_core_st_t x);
      case (i)
         3'h0: push_byte = x.program_counter[7:0];
         3'h1: push_byte = {c8rs_pkg::PC_UPPER_ZERO, x.program_counter[12:8]};
         3'h2: push_byte = x.idx;
         3'h3: push_byte = x.acc;
         default: push_byte = {c8rs_pkg::FLG_UPPER_ONES, x.condition_flags};
      endcase
   endfunction

   c8rs_stack_ram #(
      .AW    (6),
      .DW    (8)
   ) u_stack (
      .clk   (clk),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   c8rs_mul #(
      .CYCLES  (c8rs_pkg::MUL_CYCLES)
   ) u_mul (
      .clk     (clk),
      .resetn  (resetn),
      .start   (mul_start),
      .mcand   (s.acc),
      .mplier  (s.idx),
      .done    (mul_done),
      .product (mul_product)
   );

   // The control port is private to this block; the CPU bus never decodes it.
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
   assign cmd_op = c8rs_pkg::c8rs_op_t'(wb_dat_i[4:0]);
   assign cmd_go = wr && (wb_adr_i == c8rs_pkg::REG_CMD) && wb_sel_i[0]
                   && (s.state == c8rs_pkg::st_idle);
   assign irq_take = (s.state == c8rs_pkg::st_idle) && !cmd_go
                     && !s.condition_flags[c8rs_pkg::FLG_I] && (s.pend != 2'b00);
   assign take_mask = !irq_take ? 2'b00 : (s.pend[1] ? 2'b10 : 2'b01);
   assign mul_start = cmd_go && (cmd_op == c8rs_pkg::product_op);
   assign opb = s.opnd[7:0];

   assign ram_we = (s.state == c8rs_pkg::st_push);
   assign ram_addr = (s.state == c8rs_pkg::st_pull) ? 6'(s.stack_ptr + 6'h01)
                     : s.stack_ptr;
   assign ram_wdata = push_byte(s.cnt, s);

   always_comb
   begin
      case (wb_adr_i)
         c8rs_pkg::REG_OPND:   rd_value = {16'h0000, s.opnd};
         c8rs_pkg::REG_ACC:    rd_value = {24'h000000, s.acc};
         c8rs_pkg::REG_IDX:    rd_value = {24'h000000, s.idx};
         c8rs_pkg::REG_STACK:
            rd_value = {19'h00000, c8rs_pkg::STK_PAGE_BITS, s.stack_ptr};
         c8rs_pkg::REG_PC:
            rd_value = {16'h0000, c8rs_pkg::PC_UPPER_ZERO, s.program_counter};
         c8rs_pkg::REG_FLAGS:
            rd_value = {24'h000000, c8rs_pkg::FLG_UPPER_ONES, s.condition_flags};
         c8rs_pkg::REG_EA:     rd_value = {16'h0000, s.ea};
         c8rs_pkg::REG_STATUS:
            rd_value = {29'h00000000, s.pend, s.state != c8rs_pkg::st_idle};
         default:              rd_value = 32'h00000000;
      endcase
   end

   always_comb
   begin
      n = s;
      sum9 = 9'h000;
      nib = 5'h00;
      cin = 1'b0;
      nz_val = 8'h00;
      nz_upd = 1'b0;
      n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
      if (n.ack)
      begin
         n.rdat = rd_value;
      end
      n.pend = (s.pend & ~take_mask) | {irq_ext, irq_timer};
      if (wr && (wb_adr_i == c8rs_pkg::REG_OPND))
      begin
         if (wb_sel_i[0]) n.opnd[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) n.opnd[15:8] = wb_dat_i[15:8];
      end
      case (s.state)
         c8rs_pkg::st_idle:
         begin
            if (cmd_go)
            begin
               case (cmd_op)
                  c8rs_pkg::op_load_acc:
                  begin
                     n.acc = opb;
                     nz_val = opb;
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_load_idx:
                  begin
                     n.idx = opb;
                     nz_val = opb;
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_add, c8rs_pkg::op_add_carry:
                  begin
                     cin = (cmd_op == c8rs_pkg::op_add_carry)
                           & s.condition_flags[c8rs_pkg::FLG_C];
                     sum9 = {1'b0, s.acc} + {1'b0, opb} + {8'h00, cin};
                     nib = {1'b0, s.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
                     n.acc = sum9[7:0];
                     n.condition_flags[c8rs_pkg::FLG_C] = sum9[8];
                     n.condition_flags[c8rs_pkg::FLG_H] = nib[4];
                     nz_val = sum9[7:0];
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_sub:
                  begin
                     sum9 = {1'b0, s.acc} - {1'b0, opb};
                     n.acc = sum9[7:0];
                     n.condition_flags[c8rs_pkg::FLG_C] = sum9[8];
                     nz_val = sum9[7:0];
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_and, c8rs_pkg::op_or, c8rs_pkg::op_xor:
                  begin
                     if (cmd_op == c8rs_pkg::op_and) nz_val = s.acc & opb;
                     else if (cmd_op == c8rs_pkg::op_or) nz_val = s.acc | opb;
                     else nz_val = s.acc ^ opb;
                     n.acc = nz_val;
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_shift_left, c8rs_pkg::op_rot_left:
                  begin
                     nz_val = {s.acc[6:0], (cmd_op == c8rs_pkg::op_rot_left)
                               & s.condition_flags[c8rs_pkg::FLG_C]};
                     n.condition_flags[c8rs_pkg::FLG_C] = s.acc[7];
                     n.acc = nz_val;
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_shift_right, c8rs_pkg::op_rot_right:
                  begin
                     nz_val = {(cmd_op == c8rs_pkg::op_rot_right)
                               & s.condition_flags[c8rs_pkg::FLG_C], s.acc[7:1]};
                     n.condition_flags[c8rs_pkg::FLG_C] = s.acc[0];
                     n.acc = nz_val;
                     nz_upd = 1'b1;
                  end
                  c8rs_pkg::op_acc_to_idx: n.idx = s.acc;
                  c8rs_pkg::op_idx_to_acc: n.acc = s.idx;
                  c8rs_pkg::op_clear_carry: n.condition_flags[c8rs_pkg::FLG_C] = 1'b0;
                  c8rs_pkg::op_set_carry: n.condition_flags[c8rs_pkg::FLG_C] = 1'b1;
                  c8rs_pkg::op_clear_mask: n.condition_flags[c8rs_pkg::FLG_I] = 1'b0;
                  c8rs_pkg::op_set_mask: n.condition_flags[c8rs_pkg::FLG_I] = 1'b1;
                  c8rs_pkg::reload_stack_top_op: n.stack_ptr = c8rs_pkg::STK_TOP;
                  c8rs_pkg::op_fetch:
                     n.program_counter = 13'(s.program_counter + 13'h0001);
                  c8rs_pkg::op_jump: n.program_counter = s.opnd[12:0];
                  c8rs_pkg::op_subr_call:
                  begin
                     n.state = c8rs_pkg::st_push;
                     n.cnt = 3'h0;
                     n.nbytes = c8rs_pkg::PUSH_CALL;
                     n.irq_entry = 1'b0;
                  end
                  c8rs_pkg::op_subr_return, c8rs_pkg::return_from_interrupt_op:
                  begin
                     n.state = c8rs_pkg::st_pull;
                     n.phase = 1'b0;
                     n.cnt = (cmd_op == c8rs_pkg::op_subr_return)
                             ? c8rs_pkg::PULL_RET_TOP : c8rs_pkg::PULL_IRQ_TOP;
                  end
                  c8rs_pkg::product_op: n.state = c8rs_pkg::st_mul;
                  c8rs_pkg::op_index_none: n.ea = {c8rs_pkg::IX0_HIGH, s.idx};
                  c8rs_pkg::op_index_off8:
                     n.ea = {8'h00, s.idx} + {8'h00, opb};
                  c8rs_pkg::op_index_off16: n.ea = {8'h00, s.idx} + s.opnd;
                  c8rs_pkg::op_bit_test:
                     n.condition_flags[c8rs_pkg::FLG_C] = opb[s.opnd[10:8]];
                  default: n.state = c8rs_pkg::st_idle;
               endcase
            end
            else if (irq_take)
            begin
               n.state = c8rs_pkg::st_push;
               n.cnt = 3'h0;
               n.nbytes = c8rs_pkg::PUSH_IRQ;
               n.irq_entry = 1'b1;
               n.vec_ext = s.pend[1];
            end
         end
         c8rs_pkg::st_push:
         begin
            n.stack_ptr = 6'(s.stack_ptr - 6'h01);
            n.cnt = 3'(s.cnt + 3'h1);
            if (s.cnt == 3'(s.nbytes - 3'h1))
            begin
               n.state = c8rs_pkg::st_idle;
               if (s.irq_entry)
               begin
                  n.condition_flags[c8rs_pkg::FLG_I] = 1'b1;
                  n.program_counter = s.vec_ext ? VEC_EXT : VEC_TIMER;
               end
               else
               begin
                  n.program_counter = s.opnd[12:0];
               end
            end
         end
         c8rs_pkg::st_pull:
         begin
            n.phase = ~s.phase;
            if (!s.phase)
            begin
               n.stack_ptr = 6'(s.stack_ptr + 6'h01);
            end
            else
            begin
               case (s.cnt)
                  3'h0: n.program_counter[7:0] = ram_rdata;
                  3'h1: n.program_counter[12:8] = ram_rdata[4:0];
                  3'h2: n.idx = ram_rdata;
                  3'h3: n.acc = ram_rdata;
                  default: n.condition_flags = ram_rdata[4:0];
               endcase
               n.cnt = 3'(s.cnt - 3'h1);
               if (s.cnt == 3'h0)
               begin
                  n.state = c8rs_pkg::st_idle;
               end
            end
         end
         c8rs_pkg::st_mul:
         begin
            if (mul_done)
            begin
               n.acc = mul_product[7:0];
               n.idx = mul_product[15:8];
               n.condition_flags[c8rs_pkg::FLG_H] = 1'b0;
               n.condition_flags[c8rs_pkg::FLG_C] = 1'b0;
               n.state = c8rs_pkg::st_idle;
            end
         end
         default: n.state = c8rs_pkg::st_idle;
      endcase
      if (nz_upd)
      begin
         n.condition_flags[c8rs_pkg::FLG_N] = nz_val[7];
         n.condition_flags[c8rs_pkg::FLG_Z] = (nz_val == 8'h00);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
         s.stack_ptr <= c8rs_pkg::STK_TOP;
         s.condition_flags <= c8rs_pkg::FLG_RESET;
      end
      else
      begin
         s <= n;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdat;
   assign stack_addr = {3'h0, c8rs_pkg::STK_PAGE_BITS, s.stack_ptr};
   assign prog_addr = {c8rs_pkg::PC_UPPER_ZERO, s.program_counter};

   sequence seq_push5;
      ram_we [*5] ##1 !ram_we;
   endsequence

   a_irq_push_five: assert property (@(posedge clk) disable iff (!resetn)
      irq_take |=> seq_push5 ##0 s.condition_flags[c8rs_pkg::FLG_I])
      else $error("interrupt entry did not push five bytes then mask");
   a_call_push_two: assert property (@(posedge clk) disable iff (!resetn)
      cmd_go && cmd_op == c8rs_pkg::op_subr_call |=> ram_we [*2] ##1 !ram_we)
      else $error("call did not push two bytes");
   a_mask_blocks: assert property (@(posedge clk) disable iff (!resetn)
      s.state == c8rs_pkg::st_idle && s.condition_flags[c8rs_pkg::FLG_I] && !cmd_go
      |=> s.state == c8rs_pkg::st_idle)
      else $error("interrupt taken while masked");
   a_pend_held: assert property (@(posedge clk) disable iff (!resetn)
      s.condition_flags[c8rs_pkg::FLG_I] && s.pend[0] |=> s.pend[0])
      else $error("masked request lost");
   a_mask_clear: assert property (@(posedge clk) disable iff (!resetn)
      $fell(s.condition_flags[c8rs_pkg::FLG_I]) |-> $past(s.state == c8rs_pkg::st_pull)
      || $past(cmd_go && cmd_op == c8rs_pkg::op_clear_mask))
      else $error("mask cleared without an instruction");
   a_push_wrap: assert property (@(posedge clk) disable iff (!resetn)
      ram_we && s.stack_ptr == 6'h00 |=> s.stack_ptr == 6'h3F)
      else $error("stack pointer did not wrap in its page");
   a_push_step: assert property (@(posedge clk) disable iff (!resetn)
      ram_we |=> s.stack_ptr == 6'($past(s.stack_ptr) - 6'h01))
      else $error("push did not decrement the stack pointer");
   a_stack_reload: assert property (@(posedge clk) disable iff (!resetn)
      cmd_go && cmd_op == c8rs_pkg::reload_stack_top_op |=> stack_addr == 16'h00FF)
      else $error("stack reload did not reach top of stack");
   a_pc_fetch: assert property (@(posedge clk) disable iff (!resetn)
      cmd_go && cmd_op == c8rs_pkg::op_fetch
      |=> s.program_counter == 13'($past(s.program_counter) + 13'h0001))
      else $error("fetch did not advance the counter");
   a_half_carry: assert property (@(posedge clk) disable iff (!resetn)
      cmd_go && cmd_op == c8rs_pkg::op_add |=> s.condition_flags[c8rs_pkg::FLG_H]
      == (({1'b0, $past(s.acc[3:0])} + {1'b0, $past(opb[3:0])}) > 5'h0F))
      else $error("half carry wrong after add");
endmodule // c8rs_register_set
`default_nettype wire

// ==== c8rs_stack_ram.sv ====
// Stack page memory with registered read data.
`default_nettype none
module c8rs_stack_ram #(
   parameter int unsigned AW = 6,
   parameter int unsigned DW = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   if (AW < 1 || DW < 1)
   begin : g_bad_size
      $error("c8rs_stack_ram: bad size");
   end

   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0]              rd;
   } c8rs_ram_st_t;

   c8rs_ram_st_t s;
   c8rs_ram_st_t n;

   always_comb
   begin
      n = s;
      n.rd = s.mem[addr];
      if (we)
      begin
         n.mem[addr] = wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      s <= n;
   end

   assign rdata = s.rd;
endmodule // c8rs_stack_ram
`default_nettype wire

// ==== test_cpu8_register_set.sv ====
// Self-checking bench of the CPU register set against an integer model.
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_cpu8_register_set;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, resetn, cyc, stb, we, ack, ft, fe, it, ie;
   logic [7:0]  adr;
   logic [31:0] wd, rdat, rv;
   logic [15:0] sa, pa;
   logic [31:0] seed = 32'h328A;
   int          failures, compares, acc, idx, fl, a, b, k;
   int          q[$];
   c8rs_register_set u_c8rs_register_set (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_timer(it), .irq_ext(ie),
      .stack_addr(sa), .prog_addr(pa));
   c8rs_irq_src u_c8rs_irq_src (.clk(clk), .fire_tmr(ft), .fire_ext(fe),
      .irq_timer(it), .irq_ext(ie));
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed[7:0]);
   endfunction
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] ad, input int d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= ad;
      wd  <= 32'(d);
      for (n = 0; n < 50 && ack !== 1'b1; n++)
         @(posedge clk);
      if (n == 50)
      begin
         failures++;
         final_report();
      end
      rv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic op(input int code, input int opnd);
      int n;
      bus(1'b1, c8rs_pkg::REG_OPND, opnd);
      bus(1'b1, c8rs_pkg::REG_CMD, code);
      rv = 1;
      for (n = 0; n < 40 && rv[0] !== 1'b0; n++)
         bus(1'b0, c8rs_pkg::REG_STATUS, 0);
      if (n == 40)
      begin
         failures++;
         final_report();
      end
   endtask
   task automatic pins(input int s_e, input int p_e);
      `CHK("stack_addr", 32'(s_e), 32'(sa))
      `CHK("prog_addr", 32'(p_e), 32'(pa))
   endtask
   task automatic chk(input logic [7:0] ad, input int e);
      bus(1'b0, ad, 0);
      `CHK("reg", 32'(e), rv)
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {resetn, cyc, stb, we, ft, fe, adr, wd} = '0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      fl = 8;
      chk(c8rs_pkg::REG_FLAGS, 8'hE8);
      chk(c8rs_pkg::REG_STACK, 16'h00FF);
      chk(c8rs_pkg::REG_PC, 0);
      chk(8'h3C, 0);
      pins(16'h00FF, 0);
      for (k = 0; k < 6; k++)
      begin
         a = rnd();
         b = rnd();
         op(1, a);
         op(3, b);
         acc = (a + b) & 255;
         fl = 8 | (((a & 15) + (b & 15)) > 15) << 4 | (acc > 127) << 2 | (acc == 0) << 1;
         fl = fl | ((a + b) > 255);
         chk(c8rs_pkg::REG_ACC, acc);
         chk(c8rs_pkg::REG_FLAGS, 224 | fl);
      end
      $display("add test done");
      op(1, 8'h10);
      op(5, 8'h20);
      chk(c8rs_pkg::REG_ACC, 8'hF0);
      chk(c8rs_pkg::REG_FLAGS, 237 | (fl & 16));
      op(12, 0);
      chk(c8rs_pkg::REG_ACC, 8'hF8);
      op(29, 16'h0780);
      chk(c8rs_pkg::REG_FLAGS, 237 | (fl & 16));
      $display("subtract and rotate test done");
      op(2, a);
      op(1, b);
      op(25, 0);
      chk(c8rs_pkg::REG_ACC, (a * b) & 255);
      chk(c8rs_pkg::REG_IDX, (a * b) >> 8);
      idx = (a * b) >> 8;
      fl = 8 | (b > 127) << 2 | (b == 0) << 1;
      op(26, 0);
      chk(c8rs_pkg::REG_EA, idx);
      op(27, 8'hF7);
      chk(c8rs_pkg::REG_EA, idx + 8'hF7);
      op(28, 16'hFFF0);
      chk(c8rs_pkg::REG_EA, (idx + 16'hFFF0) & 16'hFFFF);
      $display("multiply and index test done");
      op(20, 0);
      q.push_back(1);
      op(22, 16'h0123);
      chk(c8rs_pkg::REG_STACK, 16'h00FD);
      chk(c8rs_pkg::REG_PC, 16'h0123);
      pins(16'h00FD, 16'h0123);
      op(23, 0);
      chk(c8rs_pkg::REG_STACK, 16'h00FF);
      chk(c8rs_pkg::REG_PC, q.pop_back());
      fe <= 1'b1;
      @(posedge clk);
      fe <= 1'b0;
      repeat (10) @(posedge clk);
      chk(c8rs_pkg::REG_PC, 1);
      chk(c8rs_pkg::REG_STATUS, 4);
      op(17, 0);
      fl = fl & 8'hF7;
      repeat (10) @(posedge clk);
      chk(c8rs_pkg::REG_STACK, 16'h00FA);
      chk(c8rs_pkg::REG_PC, 16'h1002);
      chk(c8rs_pkg::REG_FLAGS, 232 | fl);
      op(24, 0);
      chk(c8rs_pkg::REG_FLAGS, 224 | fl);
      chk(c8rs_pkg::REG_PC, 1);
      $display("interrupt test done");
      for (k = 0; k < 33; k++)
         op(22, k);
      chk(c8rs_pkg::REG_STACK, 16'h00FD);
      op(19, 0);
      chk(c8rs_pkg::REG_STACK, 16'h00FF);
      $display("stack wrap test done");
      op(18, 0);
      ft <= 1'b1;
      fe <= 1'b1;
      @(posedge clk);
      ft <= 1'b0;
      fe <= 1'b0;
      repeat (4) @(posedge clk);
      chk(c8rs_pkg::REG_STATUS, 6);
      op(17, 0);
      chk(c8rs_pkg::REG_PC, 16'h1002);
      chk(c8rs_pkg::REG_STATUS, 2);
      op(24, 0);
      repeat (10) @(posedge clk);
      chk(c8rs_pkg::REG_PC, 16'h1000);
      pins(16'h00FA, 16'h1000);
      $display("timer interrupt test done");
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk(c8rs_pkg::REG_FLAGS, 8'hE8);
      chk(c8rs_pkg::REG_STACK, 16'h00FF);
      pins(16'h00FF, 0);
      $display("second reset test done");
      final_report();
   end
endmodule // test_cpu8_register_set
`default_nettype wire
